/* spsc_pkg.sv */
// Constants, register map and types for the system power-state controller.
package spsc_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0]  CLK_CTRL_IDX   = 8'h80;
  localparam logic [7:0]  SYS_STATE_IDX  = 8'hA1;
  localparam logic [7:0]  WAKE_CAUSE_IDX = 8'hAF;
  localparam logic [7:0]  UNIT_CTRL_IDX  = 8'hB0;
  localparam logic [7:0]  IO_WAKE_IDX    = 8'hC9;
  localparam logic [11:0] CLK_CTRL_ADDR   = {2'h0, CLK_CTRL_IDX, 2'h0};
  localparam logic [11:0] SYS_STATE_ADDR  = {2'h0, SYS_STATE_IDX, 2'h0};
  localparam logic [11:0] WAKE_CAUSE_ADDR = {2'h0, WAKE_CAUSE_IDX, 2'h0};
  localparam logic [11:0] UNIT_CTRL_ADDR  = {2'h0, UNIT_CTRL_IDX, 2'h0};
  localparam logic [11:0] IO_WAKE_ADDR    = {2'h0, IO_WAKE_IDX, 2'h0};

  // Clock switch control register fields.
  localparam int CC_SRC_PLL   = 0;
  localparam int CC_SLEEP_LO  = 1;
  localparam int CC_SLEEP_HI  = 2;
  localparam int CC_CLK_OFF   = 3;
  localparam int CC_FAST_SLP  = 5;
  localparam int CC_FAST_WAKE = 6;
  localparam logic [7:0] CC_RESET = 8'h00;

  // System state register fields.
  localparam int SS_POWER_UP  = 0;
  localparam int SS_RTC_FLAG  = 2;
  localparam int SS_IO_FLAG   = 3;
  localparam int SS_PWR_FLAG  = 4;
  localparam int SS_FULL_SPD  = 5;
  localparam int SS_STATE_LSB = 6;

  // Wake cause register fields.
  localparam int WC_PULSE_FLAG = 3;

  // IO wake control register fields.
  localparam int IW_NO_RESET = 0;
  localparam int IW_PIN_LSB  = 2;
  localparam logic [7:0] IW_RESET = 8'h00;

  // Unit control register fields.
  localparam int UC_PLL_EN   = 0;
  localparam int UC_BG_EN    = 1;
  localparam int UC_ADC_LSB  = 2;
  localparam int UC_MTR_IN   = 6;
  localparam int UC_DISP_DRV = 7;
  localparam int UC_CPU_LSB  = 8;
  localparam logic [11:0] UC_RESET = 12'h000;

  // Processor clock rates; the select code gives the full-speed rate.
  localparam logic [3:0] CPU_SEL_FULL   = 4'h4;
  localparam int         CPU_FULL_HZ    = 13107200;
  localparam int         METER_FULL_HZ  = 3276800;
  localparam int         ADC_FULL_HZ    = 819200;

  // Wake pins and their hold filter: a level must last more than four cycles.
  localparam int          WAKE_PINS    = 3;
  localparam int          WAKE_HOLD_MIN = 4;
  localparam logic [2:0]  WAKE_HOLD_CYC = 3'(WAKE_HOLD_MIN + 1);

  typedef enum logic [1:0] {ST_OSC, ST_WORK, ST_GATING, ST_SLEEP} spsc_state_t;

endpackage : spsc_pkg

/* spsc_wake_if.sv */
// Carrier for filtered wake pin events between the filter and the controller.
`timescale 1ns/1ps
interface spsc_wake_if;
  import spsc_pkg::*;
  logic [WAKE_PINS-1:0] arm;   // Pin may raise a wake event.
  logic [WAKE_PINS-1:0] evt;   // One-cycle filtered transition.

  modport ctrl (output arm, input evt);
  modport filt (input arm, output evt);
endinterface : spsc_wake_if

/* spsc_wake_filter.sv */
// Wake pin hold filter: a transition counts only after both levels held long enough.
`timescale 1ns/1ps
module spsc_wake_filter
  import spsc_pkg::*;
(
  input  wire logic                 i_clk,    // Oscillator clock.
  input  wire logic                 i_rst_n,  // Synchronised reset, active low.
  input  wire logic [WAKE_PINS-1:0] i_pins,   // Raw wake pins.
  spsc_wake_if.filt                 wk        // Arm in, events out.
);

  logic [WAKE_PINS-1:0] lvl_q;
  logic [WAKE_PINS-1:0] lvl_d;
  logic [WAKE_PINS-1:0] evt_q;
  logic [WAKE_PINS-1:0] evt_d;
  logic [2:0]           cnt_q [WAKE_PINS];
  logic [2:0]           cnt_d [WAKE_PINS];

  assign wk.evt = evt_q;

  // One filter per pin; the stable level itself proves the old level was held.
  for (genvar g = 0; g < WAKE_PINS; g++) begin : g_pin
    always_comb begin
      lvl_d[g] = lvl_q[g];
      evt_d[g] = 1'b0;
      cnt_d[g] = cnt_q[g];
      if (i_pins[g] == lvl_q[g]) begin
        cnt_d[g] = 3'h0;
      end else if (cnt_q[g] == WAKE_HOLD_CYC - 3'h1) begin
        lvl_d[g] = i_pins[g];
        evt_d[g] = wk.arm[g];
        cnt_d[g] = 3'h0;
      end else begin
        cnt_d[g] = cnt_q[g] + 3'h1;
      end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        lvl_q[g] <= 1'b0;
        evt_q[g] <= 1'b0;
        cnt_q[g] <= 3'h0;
      end else begin
        lvl_q[g] <= lvl_d[g];
        evt_q[g] <= evt_d[g];
        cnt_q[g] <= cnt_d[g];
      end
    end
  end

endmodule : spsc_wake_filter

/* spsc_ctrl.sv */
// System power-state controller: state tracking, sleep entry, wake and APB registers.
//
// What this block does
// - Level one or two reset enters oscillator state, CPU clock on oscillator.
// - Oscillator state keeps core regulator on and CPU clock running.
// - Working state only while PLL enabled and selected as CPU clock.
// - Sleep entry needs power-up flag clear, oscillator source, then clock off.
// - By default a wake-up resets the device into oscillator state.
// - With wake-without-reset selected, wake resumes prior state without reset.
// - Wake without reset clears sleep-depth and fast wake/sleep bits.
// - Two sleep depths exist, light and deep.
// - Light sleep ends on IO, RTC, pulse output or power recovery.
// - Working state firmware sets CPU rate and enables each unit.
// - Full speed is 13.1072 MHz CPU, 3276.8 kHz metering, 819.2 kHz sampling.
// - At power-on metering inputs are disabled while metering clock runs.
// - At power-on display drive is disabled while display clock runs.
// - Deep sleep ends only on IO wake or power recovery.
// - Wake pin levels must each hold more than four oscillator cycles.
// - Wake cause flags distinguish pulse-output wake from RTC wake.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module spsc_ctrl
  import spsc_pkg::*;
(
  input  wire logic                 I_CORE_CLK,       // Oscillator clock, 50 MHz.
  input  wire logic                 I_ARST_N,         // Async reset, active low.
  input  wire logic                 I_PSEL,           // APB select.
  input  wire logic                 I_PENABLE,        // APB access phase.
  input  wire logic                 I_PWRITE,         // APB write.
  input  wire logic [11:0]          I_PADDR,          // APB byte address.
  input  wire logic [31:0]          I_PWDATA,         // APB write data.
  output logic      [31:0]          O_PRDATA,         // APB read data.
  output logic                      O_PREADY,         // APB ready.
  output logic                      O_PSLVERR,        // APB error on unmapped address.
  input  wire logic                 I_POWER_UP_FLAG,  // Supply still ramping when high.
  input  wire logic                 I_SRC_IS_OSC,     // Clock mux reports oscillator source.
  input  wire logic [WAKE_PINS-1:0] I_WAKE_PINS,      // Wake pins.
  input  wire logic                 I_RTC_WAKE,       // RTC wake event pulse.
  input  wire logic                 I_PULSE_WAKE,     // Energy pulse output event.
  input  wire logic                 I_PWR_RECOVER,    // Power recovery event.
  output logic                      O_CPU_CLK_EN,     // CPU clock gate enable.
  output logic                      O_CPU_SRC_PLL,    // CPU clock source is PLL.
  output logic [3:0]                O_CPU_CLK_SEL,    // CPU clock rate select.
  output logic                      O_PLL_EN,         // PLL enable.
  output logic                      O_BANDGAP_EN,     // Bandgap enable.
  output logic [3:0]                O_ADC_EN,         // Converter enables.
  output logic                      O_METER_IN_EN,    // Metering digital inputs enable.
  output logic                      O_METER_CLK_EN,   // Metering clock enable.
  output logic                      O_DISP_DRV_EN,    // Display drive enable.
  output logic                      O_DISP_CLK_EN,    // Display clock enable.
  output logic                      O_CORE_REG_EN,    // Core regulator enable.
  output logic                      O_WAKE_RST_REQ,   // One-cycle wake reset request.
  output logic [1:0]                O_STATE           // Current power state.
);

  logic        rst_s1_q;
  logic        rst_n;
  spsc_state_t state_q, state_d;
  logic [7:0]  cc_q, cc_d;
  logic [7:0]  iw_q, iw_d;
  logic [11:0] uc_q, uc_d;
  logic [2:0]  sflag_q, sflag_d;
  logic [3:0]  cause_q, cause_d;
  logic        clk_en_q, clk_en_d;
  logic        wrst_q, wrst_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  logic        deep;
  logic        light;
  logic        wake_any;
  logic        full_speed;
  logic [31:0] rd_mux;

  spsc_wake_if wk ();

  // Reset release through two flops; assertion still acts at once.
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  spsc_wake_filter u_filter (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (rst_n),
    .i_pins  (I_WAKE_PINS),
    .wk      (wk.filt)
  );

  // Pins only raise events while asleep and enabled by software.
  assign wk.arm = (state_q == ST_SLEEP) ? iw_q[IW_PIN_LSB +: WAKE_PINS] : '0;

  // APB decode; zero wait states, read data captured in the setup cycle.
  assign mapped   = (I_PADDR == CLK_CTRL_ADDR) || (I_PADDR == SYS_STATE_ADDR) ||
                    (I_PADDR == WAKE_CAUSE_ADDR) || (I_PADDR == UNIT_CTRL_ADDR) ||
                    (I_PADDR == IO_WAKE_ADDR);
  assign wr_en    = I_PSEL && I_PENABLE && I_PWRITE && mapped;
  assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
  assign O_PRDATA  = rdata_q;

  assign deep  = cc_q[CC_SLEEP_HI] && !cc_q[CC_SLEEP_LO];
  assign light = cc_q[CC_SLEEP_LO];

  assign wake_any = (|wk.evt) || I_PWR_RECOVER ||
                    (light && (I_RTC_WAKE || I_PULSE_WAKE));

  assign full_speed = (uc_q[UC_CPU_LSB +: 4] == CPU_SEL_FULL);

  // Read data selection.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (I_PADDR)
      CLK_CTRL_ADDR:   rd_mux[7:0]  = cc_q;
      SYS_STATE_ADDR:  rd_mux[7:0]  = {state_q, full_speed, sflag_q[2],
                                       sflag_q[1], sflag_q[0], 1'b0, I_POWER_UP_FLAG};
      WAKE_CAUSE_ADDR: rd_mux[3:0]  = cause_q;
      UNIT_CTRL_ADDR:  rd_mux[11:0] = uc_q;
      IO_WAKE_ADDR:    rd_mux[7:0]  = iw_q;
      default:         rd_mux       = 32'h0000_0000;
    endcase
  end

  // Next state of the power state machine, registers and wake flags.
  always_comb begin
    state_d  = state_q;
    cc_d     = cc_q;
    iw_d     = iw_q;
    uc_d     = uc_q;
    sflag_d  = sflag_q;
    cause_d  = cause_q;
    clk_en_d = clk_en_q;
    wrst_d   = 1'b0;
    rdata_d  = rd_setup ? rd_mux : rdata_q;

    // Software writes; flag registers clear by writing ones.
    if (wr_en) begin
      unique case (I_PADDR)
        CLK_CTRL_ADDR: begin
          cc_d = I_PWDATA[7:0];
          cc_d[CC_SRC_PLL] = I_PWDATA[CC_SRC_PLL] && uc_q[UC_PLL_EN];
        end
        SYS_STATE_ADDR: begin
          sflag_d = sflag_q & ~I_PWDATA[SS_PWR_FLAG:SS_RTC_FLAG];
        end
        WAKE_CAUSE_ADDR: begin
          cause_d = cause_q & ~I_PWDATA[3:0];
        end
        UNIT_CTRL_ADDR: begin
          uc_d = I_PWDATA[11:0];
          if (!I_PWDATA[UC_PLL_EN]) begin
            cc_d[CC_SRC_PLL] = 1'b0;
          end
        end
        IO_WAKE_ADDR: begin
          iw_d = I_PWDATA[7:0];
        end
        default: begin
        end
      endcase
    end

    unique case (state_q)
      ST_OSC: begin
        if (cc_d[CC_SRC_PLL] && uc_d[UC_PLL_EN]) begin
          state_d = ST_WORK;
        end else if (cc_q[CC_CLK_OFF] && !I_POWER_UP_FLAG && (light || deep)) begin
          state_d = ST_GATING;
        end
      end
      ST_WORK: begin
        if (!(cc_d[CC_SRC_PLL] && uc_d[UC_PLL_EN])) begin
          state_d = ST_OSC;
        end
      end
      ST_GATING: begin
        if (I_SRC_IS_OSC && !cc_q[CC_SRC_PLL]) begin
          clk_en_d = 1'b0;
          state_d  = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_any) begin
          clk_en_d = 1'b1;
          state_d  = ST_OSC;
          cc_d[CC_CLK_OFF] = 1'b0;
          if (iw_q[IW_NO_RESET]) begin
            cc_d[CC_SLEEP_LO]  = 1'b0;
            cc_d[CC_SLEEP_HI]  = 1'b0;
            cc_d[CC_FAST_SLP]  = 1'b0;
            cc_d[CC_FAST_WAKE] = 1'b0;
          end else begin
            wrst_d = 1'b1;
            cc_d   = CC_RESET;
            iw_d   = IW_RESET;
            uc_d   = UC_RESET;
          end
        end
      end
    endcase

    // wake cause flags; a new event wins over a clear.
    if (state_q == ST_SLEEP) begin
      if (light && (I_RTC_WAKE || I_PULSE_WAKE)) begin
        sflag_d[0] = 1'b1;
      end
      if (light && I_PULSE_WAKE) begin
        cause_d[WC_PULSE_FLAG] = 1'b1;
      end
      if (|wk.evt) begin
        sflag_d[1] = 1'b1;
        cause_d[WAKE_PINS-1:0] = cause_d[WAKE_PINS-1:0] | wk.evt;
      end
      if (I_PWR_RECOVER) begin
        sflag_d[2] = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_OSC;
      cc_q     <= CC_RESET;
      iw_q     <= IW_RESET;
      uc_q     <= UC_RESET;
      sflag_q  <= 3'h0;
      cause_q  <= 4'h0;
      clk_en_q <= 1'b1;
      wrst_q   <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      state_q  <= state_d;
      cc_q     <= cc_d;
      iw_q     <= iw_d;
      uc_q     <= uc_d;
      sflag_q  <= sflag_d;
      cause_q  <= cause_d;
      clk_en_q <= clk_en_d;
      wrst_q   <= wrst_d;
      rdata_q  <= rdata_d;
    end
  end

  // Unit controls come straight from their registers.
  // metering inputs follow UC_MTR_IN, off after reset
  assign O_CPU_CLK_EN   = clk_en_q;
  assign O_CPU_SRC_PLL  = cc_q[CC_SRC_PLL];
  assign O_CPU_CLK_SEL  = uc_q[UC_CPU_LSB +: 4];
  assign O_PLL_EN       = uc_q[UC_PLL_EN];
  assign O_BANDGAP_EN   = uc_q[UC_BG_EN];
  assign O_ADC_EN       = uc_q[UC_ADC_LSB +: 4];
  assign O_METER_IN_EN  = uc_q[UC_MTR_IN];
  assign O_DISP_DRV_EN  = uc_q[UC_DISP_DRV];
  // Metering and display clocks keep running; software stops the units.
  assign O_METER_CLK_EN = 1'b1;
  assign O_DISP_CLK_EN  = 1'b1;
  assign O_CORE_REG_EN  = 1'b1;
  assign O_WAKE_RST_REQ = wrst_q;
  assign O_STATE        = state_q;

endmodule : spsc_ctrl

/* spsc_ctrl_checker.sv */
// Port checker for the power-state controller.
`timescale 1ns/1ps
module spsc_ctrl_checker (
  input wire logic       I_CORE_CLK,      // Clock.
  input wire logic       I_ARST_N,        // Reset.
  input wire logic       I_PSEL,          // Select.
  input wire logic       I_PENABLE,       // Access.
  input wire logic       I_POWER_UP_FLAG, // Ramping.
  input wire logic       I_SRC_IS_OSC,    // Mux state.
  input wire logic       O_PSLVERR,       // Error.
  input wire logic       O_CPU_CLK_EN,    // Gate.
  input wire logic       O_CPU_SRC_PLL,   // Source.
  input wire logic       O_PLL_EN,        // PLL on.
  input wire logic       O_CORE_REG_EN,   // Regulator.
  input wire logic       O_METER_CLK_EN,  // Meter clock.
  input wire logic       O_DISP_CLK_EN,   // Display clock.
  input wire logic       O_WAKE_RST_REQ,  // Wake reset.
  input wire logic [1:0] O_STATE          // State.
);
  // One clock domain, so reset masks every check in one place.
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);

  a_osc_runs: assert property (O_STATE == 2'd0 |-> O_CORE_REG_EN && O_CPU_CLK_EN)
    else $error("oscillator state without clock or regulator");
  a_work_iff_pll: assert property ((O_STATE == 2'd1) == (O_PLL_EN && O_CPU_SRC_PLL))
    else $error("working state does not match pll use");
  a_src_after_pll: assert property (O_CPU_SRC_PLL |-> O_PLL_EN)
    else $error("pll selected while pll is off");
  a_gate_entry: assert property ((O_STATE == 2'd2 && $past(O_STATE) != 2'd2)
    |-> $past(O_STATE) == 2'd0 && !$past(I_POWER_UP_FLAG))
    else $error("gating entered from wrong state or during ramp");
  a_gate_no_trunc: assert property ($fell(O_CPU_CLK_EN)
    |-> $past(I_SRC_IS_OSC) && !$past(O_CPU_SRC_PLL) && O_STATE == 2'd3)
    else $error("clock stopped before source switch");
  a_sleep_clk_off: assert property (O_STATE == 2'd3 |-> !O_CPU_CLK_EN)
    else $error("clock running in sleep");
  a_wake_resume: assert property (($past(O_STATE) == 2'd3 && O_STATE != 2'd3)
    |-> O_STATE == 2'd0 && O_CPU_CLK_EN)
    else $error("wake did not restart in oscillator state");
  a_wake_rst_pulse: assert property (O_WAKE_RST_REQ
    |-> $past(O_STATE) == 2'd3 && O_STATE == 2'd0 ##1 !O_WAKE_RST_REQ)
    else $error("wake reset pulse misplaced");
  a_unit_clocks: assert property (O_METER_CLK_EN && O_DISP_CLK_EN)
    else $error("unit clock stopped");
  a_err_access: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
    else $error("error outside access phase");
endmodule : spsc_ctrl_checker

bind spsc_ctrl spsc_ctrl_checker spsc_ctrl_checker_inst (.I_CORE_CLK(I_CORE_CLK),
  .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_POWER_UP_FLAG(I_POWER_UP_FLAG), .I_SRC_IS_OSC(I_SRC_IS_OSC), .O_PSLVERR(O_PSLVERR),
  .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_CPU_SRC_PLL(O_CPU_SRC_PLL), .O_PLL_EN(O_PLL_EN),
  .O_CORE_REG_EN(O_CORE_REG_EN), .O_METER_CLK_EN(O_METER_CLK_EN),
  .O_DISP_CLK_EN(O_DISP_CLK_EN), .O_WAKE_RST_REQ(O_WAKE_RST_REQ), .O_STATE(O_STATE));

/* spsc_clkmux_model.sv */
// Clock source mux model: reports the new source after a chosen lag.
`timescale 1ns/1ps
module spsc_clkmux_model (
  input  wire logic       i_clk,        // Oscillator clock.
  input  wire logic       i_rst_n,      // Reset, active low.
  input  wire logic       i_src_pll,    // Requested source.
  input  wire logic [2:0] i_lag,        // Switch lag in cycles.
  output logic            o_src_is_osc  // Oscillator in use.
);
  logic [2:0] cnt_q, cnt_d;
  logic       osc_q, osc_d;
  // A real mux waits for clean edges, so a slow lag tests the gate's patience.
  always_comb begin
    cnt_d = 3'h0;
    osc_d = osc_q;
    if (i_src_pll == osc_q) begin
      cnt_d = cnt_q + 3'h1;
      if (cnt_q >= i_lag)
        osc_d = !i_src_pll;
    end
  end
  // Registers; the mux starts on the oscillator.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 3'h0;
      osc_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      osc_q <= osc_d;
    end
  end
  assign o_src_is_osc = osc_q;
endmodule : spsc_clkmux_model

/* testbench.sv */
// Self-checking bench for the power-state controller.
`timescale 1ns/1ps
module testbench;
  import spsc_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pu = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  pins = 3'h0, lag = 3'h0, evt = 3'h0;
  logic        pready, pslverr, osc, clk_en, src_pll, pll_en, bg_en, min_en, mclk, ddrv;
  logic        dclk, creg, wrq;
  logic [3:0]  sel, adc;
  logic [1:0]  st;
  int          miscompares = 0, n_compared = 0, n_wrq = 0;
  // Free-running 50 MHz clock.
  always #10 clk = ~clk;
  spsc_ctrl spsc_ctrl_inst (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_POWER_UP_FLAG(pu), .I_SRC_IS_OSC(osc),
    .I_WAKE_PINS(pins), .I_RTC_WAKE(evt[1]), .I_PULSE_WAKE(evt[2]), .I_PWR_RECOVER(evt[0]),
    .O_CPU_CLK_EN(clk_en), .O_CPU_SRC_PLL(src_pll), .O_CPU_CLK_SEL(sel), .O_PLL_EN(pll_en),
    .O_BANDGAP_EN(bg_en), .O_ADC_EN(adc), .O_METER_IN_EN(min_en), .O_METER_CLK_EN(mclk),
    .O_DISP_DRV_EN(ddrv), .O_DISP_CLK_EN(dclk), .O_CORE_REG_EN(creg), .O_WAKE_RST_REQ(wrq),
    .O_STATE(st));
  spsc_clkmux_model spsc_clkmux_model_inst (.i_clk(clk), .i_rst_n(rst_n),
    .i_src_pll(src_pll), .i_lag(lag), .o_src_is_osc(osc));
  // Count the one-cycle wake reset requests, so a missing or doubled pulse shows up.
  always @(posedge clk) if (wrq === 1'b1) n_wrq <= n_wrq + 1;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // One APB transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      conclude();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, exp, r);
  endtask : rd
  task automatic wst(input logic [1:0] s);
    int n;
    n = 0;
    while (st !== s && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("state", {30'h0, s}, {30'h0, st});
    // A state that never arrives ends the run rather than cascading.
    if (st !== s)
      conclude();
  endtask : wst
  task automatic fire(input int b);
    @(posedge clk);
    evt[b] <= 1'b1;
    @(posedge clk);
    evt <= 3'h0;
  endtask : fire
  // Main sequence: defaults, working state, then every depth against every wake source.
  initial begin
    logic [31:0] d, m;
    logic e;
    logic [2:0] dep;
    bit nr, sk;
    int src, w0;
    void'($urandom(32'h91622DFA));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("units", 32'h0, {20'h0, sel, ddrv, min_en, adc, bg_en, pll_en});
    chk("always_on", 32'h7, {29'h0, mclk, dclk, creg});
    chk("osc_state", 32'h1, {29'h0, st, clk_en});
    rd("clk_ctrl", CLK_CTRL_ADDR, 32'h0);
    rd("io_wake", IO_WAKE_ADDR, 32'h0);
    apb(1'b0, 12'h004, 32'h0, d, e);
    chk("unmapped", 32'h1, {31'h0, e});
    wr(CLK_CTRL_ADDR, 32'h1);
    rd("src_early", CLK_CTRL_ADDR, 32'h0);
    // Clock-off request without a sleep depth must not leave the oscillator state.
    wr(CLK_CTRL_ADDR, 32'h8);
    repeat (4) @(posedge clk);
    chk("no_depth", 32'h1, {29'h0, st, clk_en});
    wr(CLK_CTRL_ADDR, 32'h0);
    $display("test defaults done");
    for (int i = 0; i < 3; i++) begin
      d = ($urandom & 32'hFFF) | 32'h1;
      if (i == 0)
        d[11:8] = CPU_SEL_FULL;
      wr(UNIT_CTRL_ADDR, d);
      wr(CLK_CTRL_ADDR, 32'h1);
      @(posedge clk);
      chk("units", d, {20'h0, sel, ddrv, min_en, adc, bg_en, pll_en});
      chk("work", 32'h1, {30'h0, st});
      rd("sys_state", SYS_STATE_ADDR, {24'h0, 2'b01, d[11:8] == CPU_SEL_FULL, 5'h0});
    end
    wr(UNIT_CTRL_ADDR, 32'h0);
    @(posedge clk);
    chk("pll_off", 32'h0, {29'h0, st, src_pll});
    $display("test working state done");
    for (int i = 0; i < 8; i++) begin
      src = i % 4;
      sk = (i < 4 && src > 1);
      nr = (i < 2) ? i[0] : 1'($urandom);
      lag <= 3'($urandom % 7);
      dep = (i < 4) ? 3'h4 : (1'($urandom) ? 3'h6 : 3'h2);
      wr(IO_WAKE_ADDR, 32'h4 | {31'h0, nr});
      wr(UNIT_CTRL_ADDR, 32'h1);
      wr(CLK_CTRL_ADDR, 32'h1);
      if (i == 0)
        pu <= 1'b1;
      wr(CLK_CTRL_ADDR, 32'h68 | {29'h0, dep});
      if (i == 0) begin
        repeat (10) @(posedge clk);
        chk("ramp_hold", 32'h0, {30'h0, st});
        rd("ramp_flag", SYS_STATE_ADDR, 32'h1);
        pu <= 1'b0;
      end
      wst(2'd3);
      w0 = n_wrq;
      // A pin wake first sees a glitch that is too short to count.
      if (src == 0) begin
        @(posedge clk);
        pins[0] <= ~pins[0];
        repeat (3) @(posedge clk);
        pins[0] <= ~pins[0];
        repeat (12) @(posedge clk);
        chk("glitch", 32'h3, {30'h0, st});
        pins[0] <= ~pins[0];
      end else
        fire(src - 1);
      repeat (20) @(posedge clk);
      if (sk) begin
        chk("deep_hold", 32'h3, {30'h0, st});
        fire(0);
        repeat (5) @(posedge clk);
      end
      chk("woke", 32'h1, {29'h0, st, clk_en});
      chk("rst_pulse", {31'h0, !nr}, n_wrq - w0);
      rd("clk_ctrl", CLK_CTRL_ADDR, 32'h0);
      rd("io_wake", IO_WAKE_ADDR, nr ? 32'h5 : 32'h0);
      m = (sk || src == 1) ? 32'h10 : (src == 0 ? 32'h8 : 32'h4);
      apb(1'b0, SYS_STATE_ADDR, 32'h0, d, e);
      chk("wake_flag", m, d & m);
      apb(1'b0, WAKE_CAUSE_ADDR, 32'h0, d, e);
      chk("pulse_flag", {31'h0, src == 3 && !sk}, {31'h0, d[WC_PULSE_FLAG]});
      if (src == 0)
        chk("pin_cause", 32'h1, {31'h0, d[0]});
      wr(SYS_STATE_ADDR, 32'h1C);
      wr(WAKE_CAUSE_ADDR, 32'hF);
      $display("test sleep case %0d done", i);
    end
    conclude();
  end
endmodule : testbench
